//--- rtl/backplane_slave_data_phase.sv
// Data-phase sequencer of a memory slave on a compelled backplane bus.
// Assumes local memory control on clk_i; bus handshakes arrive asynchronous.
`timescale 1ns/1ps
module backplane_slave_data_phase (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Bus handshake pins
   input  wire logic        as_n_i,
   input  wire logic        ds_n_i,
   input  wire logic        dk_n_i,
   output logic             dk_o,
   output logic             dk_oe_o,
   input  wire logic        di_n_i,
   output logic             di_o,
   output logic             di_oe_o,
   input  wire logic        iv_n_i,
   input  wire logic        ai_n_i,
   output logic             ai_o,
   output logic             ai_oe_o,
   input  wire logic        ak_n_i,
   output logic             ak_o,
   output logic             ak_oe_o,
   input  wire logic        ed_n_i,
   output logic             ed_o,
   output logic             ed_oe_o,
   output logic             status_drive_o,
   // Connection and local memory side
   input  wire logic        conn_done_i,
   input  wire logic        read_write_select_i,
   input  wire logic        first_bank_select_i,
   input  wire logic        page_end_i,
   input  wire logic        memory_address_ready_n_i,
   input  wire logic        memory_done_toggle_i,
   output logic             memory_request_toggle_o,
   output logic             read_write_select_o,
   output logic             bank_select_o,
   output logic             xcvr_to_bus_o,
   output logic             bus_output_latch_clock_o,
   output logic             write_data_latch_enable_o,
   output logic             initial_access_flag_n_o,
   // Register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic      [31:0] reg_rdata_o
);
   // -------------------------------------------------------------------
   // Synchronised handshakes
   // -------------------------------------------------------------------
   logic [4:0]                   hs_raw;
   logic [4:0]                   hs_n;
   logic                         as_a, ds_a, dk_a, di_a, iv_a;
   data_phase_pkg::state_e       state_q;
   logic                         interv_q, init_q, write_q;
   logic [data_phase_pkg::SKEW_W-1:0] skew_q;
   logic                         tmr_start, tmr_done, mem_idle;
   logic                         odd_go, odd_act, even_go, odd_skew_end, even_skew_end;
   logic                         in_beat, wr_path;

   assign hs_raw = {iv_n_i, di_n_i, dk_n_i, ds_n_i, as_n_i};

   handshake_sync #(
      .WIDTH   (data_phase_pkg::HS_W),
      .RST_VAL (data_phase_pkg::HS_RST)
   ) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (hs_raw),
      .sync_o    (hs_n)
   );

   assign as_a = ~hs_n[data_phase_pkg::HS_AS];
   assign ds_a = ~hs_n[data_phase_pkg::HS_DS];
   assign dk_a = ~hs_n[data_phase_pkg::HS_DK];
   assign di_a = ~hs_n[data_phase_pkg::HS_DI];
   assign iv_a = ~hs_n[data_phase_pkg::HS_IV];

   // -------------------------------------------------------------------
   // Beat decode
   // -------------------------------------------------------------------
   assign mem_idle = (memory_done_toggle_i == memory_request_toggle_o);
   assign wr_path  = write_q | interv_q;
   assign odd_go   = (state_q == data_phase_pkg::S_ODD_GO) && as_a &&
                     (interv_q ? (iv_a && ds_a && dk_a) :
                      (ds_a && di_a && !dk_a && !iv_a));
   assign odd_act  = (state_q == data_phase_pkg::S_ODD_MEM) &&
                     (wr_path || mem_idle);
   assign even_go  = (state_q == data_phase_pkg::S_EVEN_GO) && as_a && !ds_a &&
                     (interv_q ? (iv_a && di_a) : (dk_a && !di_a && !iv_a));
   assign odd_skew_end  = (state_q == data_phase_pkg::S_ODD_SKEW) && tmr_done;
   assign even_skew_end = (state_q == data_phase_pkg::S_EVEN_SKEW) && tmr_done;
   assign tmr_start = odd_act || even_go;
   assign in_beat   = (state_q >= data_phase_pkg::S_ODD_GO) &&
                      (state_q <= data_phase_pkg::S_EVEN_WAIT);

   skew_timer #(
      .WIDTH (data_phase_pkg::SKEW_W)
   ) u_skew (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (tmr_start),
      .cycles_i  (skew_q),
      .done_o    (tmr_done)
   );

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q  <= data_phase_pkg::S_IDLE;
         interv_q <= 1'b0;
         write_q  <= 1'b0;
      end else begin
         unique case (state_q)
            data_phase_pkg::S_IDLE: begin
               if (as_a) begin
                  state_q <= data_phase_pkg::S_CONN;
               end
            end
            data_phase_pkg::S_CONN: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (conn_done_i) begin
                  write_q <= read_write_select_i;
                  state_q <= data_phase_pkg::S_PHASE;
               end
            end
            data_phase_pkg::S_PHASE: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (!memory_address_ready_n_i) begin
                  interv_q <= iv_a;
                  state_q  <= data_phase_pkg::S_ODD_GO;
               end
            end
            data_phase_pkg::S_ODD_GO: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (odd_go) begin
                  state_q <= data_phase_pkg::S_ODD_MEM;
               end
            end
            data_phase_pkg::S_ODD_MEM: begin
               if (odd_act) begin
                  state_q <= data_phase_pkg::S_ODD_SKEW;
               end
            end
            data_phase_pkg::S_ODD_SKEW: begin
               if (tmr_done) begin
                  state_q <= data_phase_pkg::S_ODD_WAIT;
               end
            end
            data_phase_pkg::S_ODD_WAIT: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (!ds_a && mem_idle) begin
                  state_q <= data_phase_pkg::S_EVEN_GO;
               end
            end
            data_phase_pkg::S_EVEN_GO: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (even_go) begin
                  state_q <= data_phase_pkg::S_EVEN_SKEW;
               end
            end
            data_phase_pkg::S_EVEN_SKEW: begin
               if (tmr_done) begin
                  state_q <= data_phase_pkg::S_EVEN_WAIT;
               end
            end
            data_phase_pkg::S_EVEN_WAIT: begin
               if (!as_a) begin
                  state_q <= data_phase_pkg::S_DISC;
               end else if (ds_a && mem_idle) begin
                  state_q <= data_phase_pkg::S_ODD_GO;
               end
            end
            data_phase_pkg::S_DISC: begin
               if (mem_idle) begin
                  state_q <= data_phase_pkg::S_DISC_END;
               end
            end
            data_phase_pkg::S_DISC_END: begin
               if (mem_idle) begin
                  interv_q <= 1'b0;
                  state_q  <= data_phase_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Bus handshake drivers
   // -------------------------------------------------------------------
   assign dk_o = 1'b0;
   assign di_o = 1'b0;
   assign ai_o = 1'b0;
   assign ak_o = 1'b0;
   assign ed_o = 1'b0;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dk_oe_o <= 1'b0;
         di_oe_o <= 1'b0;
         ai_oe_o <= 1'b1;
         ak_oe_o <= 1'b0;
      end else begin
         if (state_q == data_phase_pkg::S_IDLE && as_a) begin
            ak_oe_o <= 1'b1;
         end
         if (state_q == data_phase_pkg::S_CONN && conn_done_i) begin
            di_oe_o <= 1'b1;
            ai_oe_o <= 1'b0;
         end
         if (odd_act) begin
            dk_oe_o <= 1'b1;
         end
         if (odd_skew_end) begin
            di_oe_o <= 1'b0;
         end
         if (even_go) begin
            di_oe_o <= 1'b1;
         end
         if (even_skew_end) begin
            dk_oe_o <= 1'b0;
         end
         if (state_q == data_phase_pkg::S_DISC) begin
            ai_oe_o <= 1'b1;
            dk_oe_o <= 1'b0;
            di_oe_o <= 1'b0;
         end
         if (state_q == data_phase_pkg::S_DISC_END && mem_idle) begin
            ak_oe_o <= 1'b0;
         end
      end
   end

   // Status hold and end-of-data flag
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         status_drive_o <= 1'b0;
         ed_oe_o        <= 1'b0;
      end else if (state_q == data_phase_pkg::S_IDLE) begin
         status_drive_o <= 1'b0;
         ed_oe_o        <= 1'b0;
      end else begin
         if (state_q == data_phase_pkg::S_CONN && conn_done_i) begin
            status_drive_o <= 1'b1;
         end
         if (in_beat && page_end_i) begin
            ed_oe_o <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Memory module control
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         memory_request_toggle_o <= 1'b0;
         init_q                  <= 1'b1;
         xcvr_to_bus_o           <= 1'b0;
         bank_select_o           <= 1'b0;
      end else begin
         if (state_q == data_phase_pkg::S_CONN && conn_done_i) begin
            bank_select_o <= first_bank_select_i;
            init_q        <= 1'b1;
         end
         if (odd_go && !wr_path && init_q) begin
            memory_request_toggle_o <= 1'b1;
            xcvr_to_bus_o           <= 1'b1;
         end
         if (odd_act) begin
            init_q <= 1'b0;
            if (!wr_path) begin
               memory_request_toggle_o <= 1'b0;
            end
         end
         if (odd_skew_end && wr_path) begin
            memory_request_toggle_o <= 1'b1;
         end
         if (even_go && !wr_path) begin
            memory_request_toggle_o <= 1'b1;
         end
         if (even_skew_end && wr_path) begin
            memory_request_toggle_o <= 1'b0;
         end
         if (state_q == data_phase_pkg::S_DISC && mem_idle) begin
            memory_request_toggle_o <= 1'b0;
            xcvr_to_bus_o           <= 1'b0;
         end
      end
   end

   // Latch strobes and initial-access flag
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bus_output_latch_clock_o  <= 1'b0;
         write_data_latch_enable_o <= 1'b0;
         initial_access_flag_n_o   <= 1'b0;
         read_write_select_o       <= 1'b0;
      end else begin
         bus_output_latch_clock_o  <= odd_act || even_go;
         write_data_latch_enable_o <= (odd_act || even_go) && wr_path;
         read_write_select_o       <= write_q;
         if (odd_act) begin
            initial_access_flag_n_o <= 1'b1;
         end else if (state_q == data_phase_pkg::S_IDLE) begin
            initial_access_flag_n_o <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         skew_q <= data_phase_pkg::SKEW_RST;
      end else if (reg_we_i && reg_addr_i == data_phase_pkg::REG_CTRL_OFS) begin
         skew_q <= reg_wdata_i[data_phase_pkg::SKEW_LSB +: data_phase_pkg::SKEW_W];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_re_i) begin
         reg_rdata_o <= '0;
         if (reg_addr_i == data_phase_pkg::REG_CTRL_OFS) begin
            reg_rdata_o[data_phase_pkg::SKEW_LSB +: data_phase_pkg::SKEW_W] <= skew_q;
         end else if (reg_addr_i == data_phase_pkg::REG_STAT_OFS) begin
            reg_rdata_o[data_phase_pkg::STAT_STATE_LSB +: 4] <= state_q;
            reg_rdata_o[data_phase_pkg::STAT_INIT_BIT]       <= init_q;
            reg_rdata_o[data_phase_pkg::STAT_ED_BIT]         <= ed_oe_o;
            reg_rdata_o[data_phase_pkg::STAT_XCVR_BIT]       <= xcvr_to_bus_o;
            reg_rdata_o[data_phase_pkg::STAT_INTV_BIT]       <= interv_q;
         end
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   early_as_disc_a: assert property (
      (state_q == data_phase_pkg::S_ODD_GO && !as_a) |=> state_q == data_phase_pkg::S_DISC)
      else $error("early address sync release did not disconnect");

   ready_gate_a: assert property (
      (state_q == data_phase_pkg::S_PHASE && memory_address_ready_n_i)
      |=> state_q != data_phase_pkg::S_ODD_GO)
      else $error("beat entered before memory ready");

   first_rise_a: assert property (
      (odd_go && !wr_path && init_q) |=> memory_request_toggle_o && xcvr_to_bus_o)
      else $error("initial read request edge not rising");

   odd_read_a: assert property (
      (odd_act && !wr_path) |=> bus_output_latch_clock_o && dk_oe_o
      && !memory_request_toggle_o && initial_access_flag_n_o ##1 !bus_output_latch_clock_o)
      else $error("odd read beat actions missing");

   skew_release_a: assert property (
      odd_act |=> di_oe_o [*2])
      else $error("inverse acknowledge released before skew delay");

   write_req_a: assert property (
      (odd_skew_end && wr_path) |=> memory_request_toggle_o && !di_oe_o)
      else $error("odd write did not request memory after release");

   even_write_a: assert property (
      (even_go && wr_path) |=> write_data_latch_enable_o && di_oe_o)
      else $error("even write latch or inverse acknowledge missing");

   status_hold_a: assert property (
      in_beat |-> status_drive_o)
      else $error("status dropped during a beat");

   end_data_a: assert property (
      (in_beat && page_end_i) |=> ed_oe_o)
      else $error("end of data not flagged");

   disc_drive_a: assert property (
      (state_q == data_phase_pkg::S_DISC)
      |=> ai_oe_o && !dk_oe_o && !di_oe_o && ak_oe_o)
      else $error("disconnection handshake wrong");

endmodule

//--- rtl/data_phase_pkg.sv
// Shared constants and types for the backplane slave data-phase sequencer.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package data_phase_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned REG_ADDR_W   = 4;
   localparam int unsigned REG_DATA_W   = 32;
   localparam logic [3:0]  REG_CTRL_OFS = 4'h0;
   localparam logic [3:0]  REG_STAT_OFS = 4'h4;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SKEW_W        = 8;
   localparam int unsigned SKEW_LSB      = 0;
   localparam logic [7:0]  SKEW_RST      = 8'h02;
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_INIT_BIT = 8;
   localparam int unsigned STAT_ED_BIT   = 9;
   localparam int unsigned STAT_XCVR_BIT = 10;
   localparam int unsigned STAT_INTV_BIT = 11;

   // ----------------------------------------------------------------
   // Handshake bundle: bit order of the synchronised bus inputs
   // ----------------------------------------------------------------
   localparam int unsigned HS_W   = 5;
   localparam int unsigned HS_AS  = 0;
   localparam int unsigned HS_DS  = 1;
   localparam int unsigned HS_DK  = 2;
   localparam int unsigned HS_DI  = 3;
   localparam int unsigned HS_IV  = 4;
   localparam logic [4:0]  HS_RST = 5'h1f;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE,
      S_CONN,
      S_PHASE,
      S_ODD_GO,
      S_ODD_MEM,
      S_ODD_SKEW,
      S_ODD_WAIT,
      S_EVEN_GO,
      S_EVEN_SKEW,
      S_EVEN_WAIT,
      S_DISC,
      S_DISC_END
   } state_e;

endpackage

//--- rtl/handshake_sync.sv
// Three-stage synchroniser with agreement filter for bus handshake lines.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module handshake_sync #(
   parameter int unsigned WIDTH   = 5,
   parameter logic [4:0]  RST_VAL = 5'h1f
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s1_q <= RST_VAL[WIDTH-1:0];
         s2_q <= RST_VAL[WIDTH-1:0];
         s3_q <= RST_VAL[WIDTH-1:0];
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Per-bit agreement filter
   // ----------------------------------------------------------------
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            sync_o[b] <= RST_VAL[b];
         end else if (s2_q[b] == s3_q[b]) begin
            sync_o[b] <= s3_q[b];
         end
      end
   end

endmodule

//--- rtl/skew_timer.sv
// Programmable down-counter giving the transceiver skew delay.
// Assumes start_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module skew_timer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             start_i,
   input  wire logic [WIDTH-1:0] cycles_i,
   output logic                  done_o
);

   logic [WIDTH-1:0] count_q;
   logic             busy_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         count_q <= '0;
         busy_q  <= 1'b0;
         done_o  <= 1'b0;
      end else if (start_i) begin
         count_q <= (cycles_i == '0) ? WIDTH'(1) : cycles_i;
         busy_q  <= 1'b1;
         done_o  <= 1'b0;
      end else begin
         done_o <= busy_q && (count_q == WIDTH'(1));
         if (busy_q) begin
            count_q <= count_q - WIDTH'(1);
            busy_q  <= (count_q != WIDTH'(1));
         end
      end
   end

endmodule

//--- verification/dram_ctrl_model.sv
// Local DRAM controller model answering the request toggle.
// Assumes the sequencer clock; fixed answer delay in cycles.
`timescale 1ns/1ps
module dram_ctrl_model #(
   parameter int unsigned LAT = 3
) (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic req_i,
   output logic      done_o
);
   logic [7:0] cnt_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || req_i == done_o) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) done_o <= 1'b0;
      else if (cnt_q == LAT[7:0]) done_o <= req_i;
   end
endmodule

//--- verification/backplane_slave_data_phase_tb.sv
// Testbench for the backplane slave data-phase sequencer.
// Assumes dram_ctrl_model as the memory side; bench acts as bus master.
`timescale 1ns/1ps
module backplane_slave_data_phase_tb;
   typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic        clk_i, sys_rst_i, as_n, ds_n, conn, rws, bank, pend, mrdy_n, we, re;
   logic        iv_n, odk, odi;
   logic [3:0]  addr;
   logic [31:0] wd;
   wire  [31:0] rd;
   wire         dk_oe, di_oe, ai_oe, ak_oe, ed_oe, req, done, xcvr, init_n, bsel, rwo, sdrv;
   wire  [4:0]  obs = {ed_oe, ak_oe, ai_oe, di_oe, dk_oe};
   int          fails = 0;
   int          compares = 0;
   row_s        rows [5] = '{'{1'b0, 4'h0, 32'h0, 32'h2}, '{1'b1, 4'h0, 32'h3, 32'h0},
                             '{1'b0, 4'h0, 32'h0, 32'h3}, '{1'b0, 4'h8, 32'h0, 32'h0},
                             '{1'b0, 4'h4, 32'h0, 32'h100}};
   backplane_slave_data_phase i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .as_n_i(as_n),
      .ds_n_i(ds_n), .dk_n_i(~(dk_oe | odk)), .dk_o(), .dk_oe_o(dk_oe), .di_o(),
      .di_n_i(~(di_oe | odi)), .di_oe_o(di_oe), .iv_n_i(iv_n), .ai_n_i(~ai_oe), .ai_o(),
      .ai_oe_o(ai_oe),
      .ak_n_i(~ak_oe), .ak_o(), .ak_oe_o(ak_oe), .ed_n_i(~ed_oe), .ed_o(), .ed_oe_o(ed_oe),
      .status_drive_o(sdrv), .conn_done_i(conn), .read_write_select_i(rws),
      .first_bank_select_i(bank), .page_end_i(pend), .memory_address_ready_n_i(mrdy_n),
      .memory_done_toggle_i(done), .memory_request_toggle_o(req),
      .read_write_select_o(rwo), .bank_select_o(bsel), .xcvr_to_bus_o(xcvr),
      .bus_output_latch_clock_o(), .write_data_latch_enable_o(),
      .initial_access_flag_n_o(init_n), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd));
   dram_ctrl_model i_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .done_o(done));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic complete_run();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_lvl(input int i, input logic v);
      int n;
      n = 0;
      while (obs[i] !== v && n < 300) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk({31'h0, obs[i]}, {31'h0, v});
      if (obs[i] !== v) complete_run();
   endtask
   task automatic burst(input logic w, input logic v);
      @(posedge clk_i);
      as_n <= 1'b0;
      rws <= w;
      pend <= w;
      iv_n <= ~v;
      wait_lvl(3, 1'b1);
      @(posedge clk_i);
      conn <= 1'b1;
      @(posedge clk_i);
      conn <= 1'b0;
      mrdy_n <= 1'b0;
      ds_n <= 1'b0;
      odk <= v;
      wait_lvl(0, 1'b1);
      chk({31'h0, rwo}, {31'h0, w});
      chk({31'h0, bsel}, 32'h1);
      chk({31'h0, init_n}, 32'h1);
      chk({31'h0, xcvr}, {31'h0, ~(w | v)});
      chk({31'h0, sdrv}, 32'h1);
      wait_lvl(1, 1'b0);
      chk({31'h0, req}, {31'h0, w | v});
      @(posedge clk_i);
      ds_n <= 1'b1;
      odi <= v;
      wait_lvl(1, 1'b1);
      wait_lvl(0, 1'b0);
      chk({31'h0, req}, {31'h0, ~(w | v)});
      chk({31'h0, ed_oe}, {31'h0, w});
      @(posedge clk_i);
      as_n <= 1'b1;
      mrdy_n <= 1'b1;
      iv_n <= 1'b1;
      {odk, odi} <= 2'h0;
      wait_lvl(2, 1'b1);
      chk({30'h0, obs[1:0]}, 32'h0);
      wait_lvl(3, 1'b0);
      $display("burst done");
   endtask
   initial begin
      {as_n, ds_n, mrdy_n, bank} = 4'hf;
      {iv_n, odk, odi} = 3'h4;
      {sys_rst_i, conn, rws, pend, we, re} = 6'h20;
      addr = 4'h0;
      wd = 32'h0;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      foreach (rows[k]) begin
         @(posedge clk_i);
         we <= rows[k].w;
         re <= ~rows[k].w;
         addr <= rows[k].a;
         wd <= rows[k].d;
         @(posedge clk_i);
         {we, re} <= 2'h0;
         #1 if (!rows[k].w) chk(rd, rows[k].e);
      end
      $display("register test done");
      burst(1'b1, 1'b0);
      burst(1'b0, 1'b0);
      burst(1'b0, 1'b1);
      @(posedge clk_i);
      as_n <= 1'b0;
      wait_lvl(3, 1'b1);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      as_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 chk({27'h0, obs}, 32'h4);
      chk({31'h0, req}, 32'h0);
      $display("reset test done");
      complete_run();
   end
endmodule
